// *** hw/dps_sem_host.sv ***
// How it works
// - Host straps exactly one master per array
// - Hold address and select before write strobe
// - Memory chip select high during semaphore access
// - Drop select or enable between polling reads
// - Acquire by write zero then read back
// - Failed request: keep reading or write one
// - Software writes one to all semaphores at start
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`include "dps_defs.svh"
`default_nettype none
module dps_sem_host #(
  parameter int SETUP_CYC = `DPS_SETUP_CYC,
  parameter int PULSE_CYC = `DPS_PULSE_CYC,
  parameter int GAP_CYC   = `DPS_GAP_CYC
) (
  input  wire logic        aclk,           // System clock
  input  wire logic        aresetn,        // Sync reset
  input  wire logic [7:0]  s_axi_awaddr,   // Write address
  input  wire logic        s_axi_awvalid,  // Write address valid
  output logic             s_axi_awready,  // Write address ready
  input  wire logic [31:0] s_axi_wdata,    // Write data
  input  wire logic [3:0]  s_axi_wstrb,    // Byte strobes
  input  wire logic        s_axi_wvalid,   // Write data valid
  output logic             s_axi_wready,   // Write data ready
  output logic [1:0]       s_axi_bresp,    // Write response
  output logic             s_axi_bvalid,   // Write response valid
  input  wire logic        s_axi_bready,   // Write response ready
  input  wire logic [7:0]  s_axi_araddr,   // Read address
  input  wire logic        s_axi_arvalid,  // Read address valid
  output logic             s_axi_arready,  // Read address ready
  output logic [31:0]      s_axi_rdata,    // Read data
  output logic [1:0]       s_axi_rresp,    // Read response
  output logic             s_axi_rvalid,   // Read data valid
  input  wire logic        s_axi_rready,   // Read data ready
  output logic             port_ce_n,      // Memory chip select
  output logic             port_semaphore_select_n, // Semaphore space select
  output logic             port_rw_n,      // Read/write, low writes
  output logic             port_oe_n,      // Output enable
  output logic [16:0]      port_addr,      // Address pins
  output logic [8:0]       port_data_o,    // Data out
  output logic             port_data_oe,   // Data drive enable
  input  wire logic [8:0]  port_data_i,    // Data in
  input  wire logic        port_busy_n,    // Conflict flag from part
  output logic             ms_sel          // Master/slave strap to part
);
  // ********************************
  // Pin engine
  // ********************************
  dps_eng_if eif ();

  dps_port_eng #(
    .SETUP_CYC (SETUP_CYC),
    .PULSE_CYC (PULSE_CYC),
    .GAP_CYC   (GAP_CYC)
  ) u_eng (
    .aclk    (aclk),
    .aresetn (aresetn),
    .e       (eif.eng),
    .ce_n    (port_ce_n),
    .sem_n   (port_semaphore_select_n),
    .rw_n    (port_rw_n),
    .oe_n    (port_oe_n),
    .addr    (port_addr),
    .dout    (port_data_o),
    .dout_oe (port_data_oe),
    .din     (port_data_i),
    .busy_n  (port_busy_n)
  );

  function automatic logic dps_mapped(input logic [7:0] a);
    dps_mapped = (a[1:0] == 2'h0) && (a <= `DPS_REG_CFG);
  endfunction

  function automatic logic [31:0] dps_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    dps_merge = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        dps_merge[i*8 +: 8] = nw[i*8 +: 8];
  endfunction

  // ********************************
  // AXI4-Lite slave and registers
  // ********************************
  logic        awh_r, awh_nxt, wh_r, wh_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic [7:0]  awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [3:0]  ws_r, ws_nxt;
  logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
  logic [16:0] addr_r, addr_nxt;
  logic [8:0]  wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic        ms_r, ms_nxt;
  logic [7:0]  poll_r, poll_nxt;
  logic        done_r, done_nxt, grant_r, grant_nxt, conf_r, conf_nxt, fail_r, fail_nxt;
  logic        go;
  logic [2:0]  go_op;
  logic [31:0] status;
  logic [31:0] cfg_word;

  // ********************************
  // Command sequencer
  // ********************************
  dps_pkg::dps_seq_e   st_r, st_nxt;
  dps_pkg::dps_phase_e ph_r, ph_nxt;
  logic        req_r, req_nxt, awr_r, awr_nxt, asem_r, asem_nxt;
  logic [16:0] aadr_r, aadr_nxt;
  logic [8:0]  adat_r, adat_nxt;
  logic [2:0]  idx_r, idx_nxt;
  logic [7:0]  pl_r, pl_nxt;
  logic        seq_busy;

  assign seq_busy = (st_r != dps_pkg::M_IDLE);
  assign status   = {27'h0, fail_r, conf_r, grant_r, done_r, seq_busy};
  assign cfg_word = {16'h0, poll_r, 7'h0, ms_r};
  assign s_axi_awready = !awh_r && !bv_r;
  assign s_axi_wready  = !wh_r && !bv_r;
  assign s_axi_arready = !rv_r;

  always_comb
  begin
    awh_nxt = awh_r; wh_nxt = wh_r; bv_nxt = bv_r; rv_nxt = rv_r;
    awa_nxt = awa_r; wd_nxt = wd_r; ws_nxt = ws_r; rd_nxt = rd_r; br_nxt = br_r; rr_nxt = rr_r;
    addr_nxt = addr_r; wdata_nxt = wdata_r; ms_nxt = ms_r; poll_nxt = poll_r;
    go = 1'b0;
    go_op = 3'h0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      awh_nxt = 1'b1;
      awa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      wh_nxt = 1'b1;
      wd_nxt = s_axi_wdata;
      ws_nxt = s_axi_wstrb;
    end
    if (awh_r && wh_r)
    begin
      awh_nxt = 1'b0;
      wh_nxt  = 1'b0;
      bv_nxt  = 1'b1;
      br_nxt  = dps_mapped(awa_r) ? `DPS_RESP_OKAY : `DPS_RESP_SLVERR;
      case (awa_r)
        `DPS_REG_CTRL:
        begin
          // Commands while busy are dropped; software polls the busy bit first
          go    = !seq_busy && ws_r[0];
          go_op = wd_r[2:0];
        end
        `DPS_REG_ADDR:
          addr_nxt = 17'(dps_merge({15'h0, addr_r}, wd_r, ws_r));
        `DPS_REG_WDATA:
          wdata_nxt = 9'(dps_merge({23'h0, wdata_r}, wd_r, ws_r));
        `DPS_REG_CFG:
        begin
          ms_nxt   = 1'(dps_merge(cfg_word, wd_r, ws_r) >> `DPS_CFG_MS);
          poll_nxt = 8'(dps_merge(cfg_word, wd_r, ws_r) >> `DPS_CFG_POLL_LSB);
        end
        default:
          go = 1'b0;
      endcase
    end
    if (bv_r && s_axi_bready)
      bv_nxt = 1'b0;
    if (rv_r && s_axi_rready)
      rv_nxt = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rv_nxt = 1'b1;
      rr_nxt = dps_mapped(s_axi_araddr) ? `DPS_RESP_OKAY : `DPS_RESP_SLVERR;
      case (s_axi_araddr)
        `DPS_REG_ADDR:   rd_nxt = {15'h0, addr_r};
        `DPS_REG_WDATA:  rd_nxt = {23'h0, wdata_r};
        `DPS_REG_STATUS: rd_nxt = status;
        `DPS_REG_RDATA:  rd_nxt = {23'h0, rdata_r};
        `DPS_REG_CFG:    rd_nxt = cfg_word;
        default:         rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_comb
  begin
    st_nxt = st_r; ph_nxt = ph_r; req_nxt = req_r; awr_nxt = awr_r; asem_nxt = asem_r;
    aadr_nxt = aadr_r; adat_nxt = adat_r; idx_nxt = idx_r; pl_nxt = pl_r;
    rdata_nxt = rdata_r; done_nxt = done_r; grant_nxt = grant_r; conf_nxt = conf_r;
    fail_nxt = fail_r;
    case (st_r)
      dps_pkg::M_IDLE:
        if (go && go_op <= `DPS_OP_INIT)
        begin
          done_nxt = 1'b0; grant_nxt = 1'b0; conf_nxt = 1'b0; fail_nxt = 1'b0;
          req_nxt  = 1'b1;
          st_nxt   = dps_pkg::M_RUN;
          ph_nxt   = dps_pkg::PH_SINGLE;
          aadr_nxt = addr_r;
          adat_nxt = wdata_r;
          awr_nxt  = (go_op != `DPS_OP_MEM_RD);
          asem_nxt = (go_op >= `DPS_OP_ACQUIRE);
          idx_nxt  = addr_r[2:0];
          pl_nxt   = poll_r;
          if (go_op >= `DPS_OP_ACQUIRE)
            aadr_nxt = {14'h0, addr_r[2:0]};
          if (go_op == `DPS_OP_ACQUIRE)
          begin
            adat_nxt = 9'h000;
            ph_nxt   = dps_pkg::PH_ACQ_W;
          end
          if (go_op == `DPS_OP_RELEASE)
            adat_nxt = 9'h001;
          if (go_op == `DPS_OP_INIT)
          begin
            aadr_nxt = 17'h00000;
            idx_nxt  = 3'h0;
            adat_nxt = 9'h001;
            ph_nxt   = dps_pkg::PH_INIT;
          end
        end
      dps_pkg::M_RUN:
        if (eif.done)
        begin
          req_nxt   = 1'b0;
          rdata_nxt = eif.rdata;
          conf_nxt  = conf_r | eif.conflict;
          st_nxt    = dps_pkg::M_EVAL;
        end
      dps_pkg::M_EVAL:
      begin
        st_nxt  = dps_pkg::M_RUN;
        req_nxt = 1'b1;
        case (ph_r)
          dps_pkg::PH_ACQ_W:
          begin
            awr_nxt = 1'b0;
            ph_nxt  = dps_pkg::PH_ACQ_R;
          end
          dps_pkg::PH_ACQ_R:
            if (!rdata_r[0])
            begin
              grant_nxt = 1'b1;
              done_nxt  = 1'b1;
              req_nxt   = 1'b0;
              st_nxt    = dps_pkg::M_IDLE;
            end
            else if (pl_r != 8'h00)
              pl_nxt = pl_r - 8'h01;
            else
            begin
              // Withdraw so a stale request never seizes the token later
              fail_nxt = 1'b1;
              awr_nxt  = 1'b1;
              adat_nxt = 9'h001;
              ph_nxt   = dps_pkg::PH_SINGLE;
            end
          dps_pkg::PH_INIT:
            if (idx_r == 3'(`DPS_NSEM - 1))
            begin
              done_nxt = 1'b1;
              req_nxt  = 1'b0;
              st_nxt   = dps_pkg::M_IDLE;
            end
            else
            begin
              idx_nxt  = idx_r + 3'h1;
              aadr_nxt = {14'h0, idx_r + 3'h1};
            end
          default:
          begin
            done_nxt = 1'b1;
            req_nxt  = 1'b0;
            st_nxt   = dps_pkg::M_IDLE;
          end
        endcase
      end
      default:
        st_nxt = dps_pkg::M_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awh_r <= 1'b0; wh_r <= 1'b0; bv_r <= 1'b0; rv_r <= 1'b0;
      awa_r <= 8'h00; wd_r <= 32'h0000_0000; ws_r <= 4'h0; rd_r <= 32'h0000_0000;
      br_r <= `DPS_RESP_OKAY; rr_r <= `DPS_RESP_OKAY;
      addr_r <= 17'h00000; wdata_r <= 9'h000; rdata_r <= 9'h000;
      ms_r <= 1'(`DPS_CFG_RESET >> `DPS_CFG_MS);
      poll_r <= 8'(`DPS_CFG_RESET >> `DPS_CFG_POLL_LSB);
      done_r <= 1'b0; grant_r <= 1'b0; conf_r <= 1'b0; fail_r <= 1'b0;
      st_r <= dps_pkg::M_IDLE; ph_r <= dps_pkg::PH_SINGLE; req_r <= 1'b0;
      awr_r <= 1'b0; asem_r <= 1'b0; aadr_r <= 17'h00000; adat_r <= 9'h000;
      idx_r <= 3'h0; pl_r <= 8'h00;
    end
    else
    begin
      awh_r <= awh_nxt; wh_r <= wh_nxt; bv_r <= bv_nxt; rv_r <= rv_nxt;
      awa_r <= awa_nxt; wd_r <= wd_nxt; ws_r <= ws_nxt; rd_r <= rd_nxt;
      br_r <= br_nxt; rr_r <= rr_nxt;
      addr_r <= addr_nxt; wdata_r <= wdata_nxt; rdata_r <= rdata_nxt;
      ms_r <= ms_nxt; poll_r <= poll_nxt;
      done_r <= done_nxt; grant_r <= grant_nxt; conf_r <= conf_nxt; fail_r <= fail_nxt;
      st_r <= st_nxt; ph_r <= ph_nxt; req_r <= req_nxt;
      awr_r <= awr_nxt; asem_r <= asem_nxt; aadr_r <= aadr_nxt; adat_r <= adat_nxt;
      idx_r <= idx_nxt; pl_r <= pl_nxt;
    end
  end

  assign eif.req   = req_r;
  assign eif.wr    = awr_r;
  assign eif.sem   = asem_r;
  assign eif.addr  = aadr_r;
  assign eif.wdata = adat_r;
  assign s_axi_bvalid = bv_r;
  assign s_axi_bresp  = br_r;
  assign s_axi_rvalid = rv_r;
  assign s_axi_rresp  = rr_r;
  assign s_axi_rdata  = rd_r;
  assign ms_sel       = ms_r;
endmodule
`default_nettype wire

// *** hw/dps_defs.svh ***
`ifndef DPS_DEFS_SVH
`define DPS_DEFS_SVH

// ********************************
// Clock and pin timing
// ********************************
`define DPS_CLK_NS        20
`define DPS_T_SETUP_NS    40
`define DPS_T_PULSE_NS    100
`define DPS_T_GAP_NS      40
`define DPS_CYC_UP(ns)    ((((ns) + `DPS_CLK_NS - 1) / `DPS_CLK_NS))
`define DPS_SETUP_CYC     `DPS_CYC_UP(`DPS_T_SETUP_NS)
`define DPS_PULSE_CYC     `DPS_CYC_UP(`DPS_T_PULSE_NS)
`define DPS_GAP_CYC       `DPS_CYC_UP(`DPS_T_GAP_NS)
`define DPS_NSEM          8

// ********************************
// Registers, commands and fields
// ********************************
`define DPS_REG_CTRL      8'h00
`define DPS_REG_ADDR      8'h04
`define DPS_REG_WDATA     8'h08
`define DPS_REG_STATUS    8'h0c
`define DPS_REG_RDATA     8'h10
`define DPS_REG_CFG       8'h14
`define DPS_OP_MEM_RD     3'h0
`define DPS_OP_MEM_WR     3'h1
`define DPS_OP_ACQUIRE    3'h2
`define DPS_OP_RELEASE    3'h3
`define DPS_OP_INIT       3'h4
`define DPS_ST_BUSY       0
`define DPS_ST_DONE       1
`define DPS_ST_GRANTED    2
`define DPS_ST_CONFLICT   3
`define DPS_ST_FAILED     4
`define DPS_CFG_MS        0
`define DPS_CFG_POLL_LSB  8
`define DPS_CFG_RESET     32'h0000_0001
`define DPS_RESP_OKAY     2'h0
`define DPS_RESP_SLVERR   2'h2

`endif

// *** hw/dps_pkg.sv ***
`default_nettype none
package dps_pkg;
  typedef enum logic [2:0] {E_IDLE, E_SETUP, E_PULSE, E_GAP, E_DONE} dps_eng_e;
  typedef enum logic [1:0] {M_IDLE, M_RUN, M_EVAL} dps_seq_e;
  typedef enum logic [1:0] {PH_SINGLE, PH_ACQ_W, PH_ACQ_R, PH_INIT} dps_phase_e;
endpackage
`default_nettype wire

// *** hw/dps_eng_if.sv ***
`default_nettype none
interface dps_eng_if;
  logic        req;
  logic        wr;
  logic        sem;
  logic [16:0] addr;
  logic [8:0]  wdata;
  logic        done;
  logic [8:0]  rdata;
  logic        conflict;
  modport seq (output req, wr, sem, addr, wdata, input done, rdata, conflict);
  modport eng (input req, wr, sem, addr, wdata, output done, rdata, conflict);
endinterface
`default_nettype wire

// *** hw/dps_port_eng.sv ***
`include "dps_defs.svh"
`default_nettype none
module dps_port_eng #(
  parameter int SETUP_CYC = `DPS_SETUP_CYC,
  parameter int PULSE_CYC = `DPS_PULSE_CYC,
  parameter int GAP_CYC   = `DPS_GAP_CYC
) (
  input  wire logic        aclk,      // System clock
  input  wire logic        aresetn,   // Sync reset
  dps_eng_if.eng           e,         // Access requests
  output logic             ce_n,      // Memory chip select
  output logic             sem_n,     // semaphore_select
  output logic             rw_n,      // Write strobe, low writes
  output logic             oe_n,      // Output enable
  output logic [16:0]      addr,      // Address pins
  output logic [8:0]       dout,      // Data to pins
  output logic             dout_oe,   // Data drive enable
  input  wire logic [8:0]  din,       // Data from pins
  input  wire logic        busy_n     // Conflict flag from the part
);
  if (SETUP_CYC < 1 || SETUP_CYC > 254 || PULSE_CYC < 3 || PULSE_CYC > 255 ||
      GAP_CYC < 1 || GAP_CYC > 255)
    $error("dps_port_eng: timing counts out of range");

  // ********************************
  // Pin input synchronisers
  // ********************************
  logic [8:0] din_m_r, din_s_r;
  logic       busy_m_r, busy_s_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      din_m_r  <= 9'h000;
      din_s_r  <= 9'h000;
      busy_m_r <= 1'b1;
      busy_s_r <= 1'b1;
    end
    else
    begin
      din_m_r  <= din;
      din_s_r  <= din_m_r;
      busy_m_r <= busy_n;
      busy_s_r <= busy_m_r;
    end
  end

  // ********************************
  // Access sequencer
  // ********************************
  dps_pkg::dps_eng_e st_r, st_nxt;
  logic [7:0]  cnt_r, cnt_nxt;
  logic        wr_r, wr_nxt, sem_r, sem_nxt, conf_r, conf_nxt;
  logic        ce_n_r, ce_n_nxt, sem_n_r, sem_n_nxt, rw_n_r, rw_n_nxt, oe_n_r, oe_n_nxt;
  logic        doe_r, doe_nxt;
  logic [16:0] addr_r, addr_nxt;
  logic [8:0]  dout_r, dout_nxt, rdata_r, rdata_nxt;

  always_comb
  begin
    st_nxt = st_r; cnt_nxt = cnt_r; wr_nxt = wr_r; sem_nxt = sem_r; conf_nxt = conf_r;
    ce_n_nxt = ce_n_r; sem_n_nxt = sem_n_r; rw_n_nxt = rw_n_r; oe_n_nxt = oe_n_r;
    doe_nxt = doe_r; addr_nxt = addr_r; dout_nxt = dout_r; rdata_nxt = rdata_r;
    case (st_r)
      dps_pkg::E_IDLE:
        if (e.req)
        begin
          wr_nxt    = e.wr;
          sem_nxt   = e.sem;
          conf_nxt  = 1'b0;
          addr_nxt  = e.addr;
          dout_nxt  = e.wdata;
          doe_nxt   = e.wr;
          ce_n_nxt  = e.sem;
          sem_n_nxt = !e.sem;
          cnt_nxt   = (e.wr && !e.sem) ? 8'(SETUP_CYC + 1) : 8'(SETUP_CYC - 1);
          st_nxt    = dps_pkg::E_SETUP;
        end
      dps_pkg::E_SETUP:
        if (cnt_r != 8'h00)
          cnt_nxt = cnt_r - 8'h01;
        else if (wr_r && !sem_r && !busy_s_r)
          conf_nxt = 1'b1;  // Stall the memory write while flagged; semaphores never wait
        else
        begin
          rw_n_nxt = !wr_r;
          oe_n_nxt = wr_r;
          cnt_nxt  = 8'(PULSE_CYC - 1);
          st_nxt   = dps_pkg::E_PULSE;
        end
      dps_pkg::E_PULSE:
        if (cnt_r != 8'h00)
          cnt_nxt = cnt_r - 8'h01;
        else
        begin
          rdata_nxt = din_s_r;
          if (wr_r && !sem_r && !busy_s_r)
            conf_nxt = 1'b1;  // Write may have been inhibited
          rw_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          cnt_nxt  = 8'(GAP_CYC - 1);
          st_nxt   = dps_pkg::E_GAP;
        end
      dps_pkg::E_GAP:
        if (cnt_r != 8'h00)
          cnt_nxt = cnt_r - 8'h01;
        else
        begin
          ce_n_nxt  = 1'b1;
          sem_n_nxt = 1'b1;
          doe_nxt   = 1'b0;
          st_nxt    = dps_pkg::E_DONE;
        end
      dps_pkg::E_DONE:
        st_nxt = dps_pkg::E_IDLE;
      default:
        st_nxt = dps_pkg::E_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= dps_pkg::E_IDLE; cnt_r <= 8'h00; wr_r <= 1'b0; sem_r <= 1'b0; conf_r <= 1'b0;
      ce_n_r <= 1'b1; sem_n_r <= 1'b1; rw_n_r <= 1'b1; oe_n_r <= 1'b1; doe_r <= 1'b0;
      addr_r <= 17'h00000; dout_r <= 9'h000; rdata_r <= 9'h000;
    end
    else
    begin
      st_r <= st_nxt; cnt_r <= cnt_nxt; wr_r <= wr_nxt; sem_r <= sem_nxt; conf_r <= conf_nxt;
      ce_n_r <= ce_n_nxt; sem_n_r <= sem_n_nxt; rw_n_r <= rw_n_nxt; oe_n_r <= oe_n_nxt;
      doe_r <= doe_nxt; addr_r <= addr_nxt; dout_r <= dout_nxt; rdata_r <= rdata_nxt;
    end
  end

  assign e.done     = (st_r == dps_pkg::E_DONE);
  assign e.rdata    = rdata_r;
  assign e.conflict = conf_r;
  assign ce_n    = ce_n_r;
  assign sem_n   = sem_n_r;
  assign rw_n    = rw_n_r;
  assign oe_n    = oe_n_r;
  assign addr    = addr_r;
  assign dout    = dout_r;
  assign dout_oe = doe_r;
endmodule
`default_nettype wire

// *** tb/dps_dev_model.sv ***
`default_nettype none
module dps_dev_model (
  input  wire logic        port_ce_n,               // Memory select
  input  wire logic        port_semaphore_select_n, // Token space select
  input  wire logic        port_rw_n,               // Low writes
  input  wire logic        port_oe_n,               // Output enable
  input  wire logic [16:0] port_addr,               // Address
  input  wire logic [8:0]  port_data_o,             // Host data
  input  wire logic        port_data_oe,            // Host drives
  output logic      [8:0]  port_data_i,             // Bus level
  output logic             port_busy_n,             // Conflict flag
  input  wire logic        bsy,                     // Far port wins
  input  wire logic        o_wr,                    // Far port write
  input  wire logic [2:0]  o_idx,                   // Far port index
  input  wire logic        o_val,                   // Far port bit
  output logic      [7:0]  o_flag                   // Far port view
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********************************
  // Token latches
  // ********************************
  // No power-up clear: host latches come up requesting
  logic [7:0] req_l = 8'h00, req_r = 8'h00;
  logic [7:0] own_l = 8'h00, own_r = 8'h00;
  logic [8:0] q     = 9'h000;
  logic [8:0] mem [int];
  wire        tok_rd = !port_semaphore_select_n && !port_oe_n;
  wire        mem_rd = !port_ce_n && !port_oe_n;
  task automatic settle(input logic [2:0] i);
    if (own_l[i] && req_l[i]) own_l[i] = 1'b0;
    if (own_r[i] && req_r[i]) own_r[i] = 1'b0;
    if (!own_l[i] && !own_r[i] && !req_l[i]) own_l[i] = 1'b1;
    if (!own_l[i] && !own_r[i] && !req_r[i]) own_r[i] = 1'b1;
  endtask
  always @(posedge port_rw_n)
  begin
    if (!port_semaphore_select_n) req_l[port_addr[2:0]] = port_data_o[0];
    if (!port_semaphore_select_n) settle(port_addr[2:0]);
    if (!port_ce_n && port_busy_n) mem[port_addr] = port_data_o;
  end
  always @(posedge o_wr)
  begin
    req_r[o_idx] = o_val;
    settle(o_idx);
  end
  always @(posedge tok_rd) q = {9{!own_l[port_addr[2:0]]}};
  always @(posedge mem_rd) q = mem.exists(port_addr) ? mem[port_addr] : 9'h000;
  // Idle bus shows inverted data so a late sample cannot pass
  assign port_data_i = port_data_oe ? port_data_o : (tok_rd || mem_rd) ? q : ~q;
  assign port_busy_n = !(bsy && !port_ce_n);
  assign o_flag      = ~own_r;
endmodule
`default_nettype wire

// *** tb/dps_sem_host_asserts.sv ***
`default_nettype none
module dps_sem_host_asserts #(
  parameter int SETUP_CYC = 2
) (
  input wire logic        aclk,                    // Clock
  input wire logic        aresetn,                 // Sync reset
  input wire logic        s_axi_awready,           // Write address ready
  input wire logic        s_axi_wready,            // Write data ready
  input wire logic        s_axi_bvalid,            // Write response valid
  input wire logic        s_axi_arvalid,           // Read address valid
  input wire logic        s_axi_arready,           // Read address ready
  input wire logic        s_axi_rvalid,            // Read data valid
  input wire logic        port_ce_n,               // Memory select
  input wire logic        port_semaphore_select_n, // Token select
  input wire logic        port_rw_n,               // Write strobe
  input wire logic        port_oe_n,               // Output enable
  input wire logic [16:0] port_addr,               // Address
  input wire logic        port_data_oe             // Data drive
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_pulse;
    (!port_rw_n && port_data_oe) [*5] ##1 port_rw_n;
  endsequence
  sequence s_rd_pulse;
    (!port_oe_n && !port_data_oe) [*5] ##1 port_oe_n;
  endsequence
  AST_TOK_CE: assert property (!port_semaphore_select_n |-> port_ce_n)
    else $error("Memory select low in token cycle");
  AST_TOK_IDX: assert property (!port_semaphore_select_n |-> port_addr[16:3] == 14'h0000)
    else $error("Upper index bits set");
  AST_WR_SETUP: assert property ($fell(port_rw_n) |->
    $past(!port_ce_n || !port_semaphore_select_n, SETUP_CYC))
    else $error("Write strobe before select setup");
  AST_WR_PULSE: assert property ($fell(port_rw_n) |-> s_wr_pulse)
    else $error("Bad write pulse");
  AST_RD_PULSE: assert property ($fell(port_oe_n) |-> s_rd_pulse)
    else $error("Bad read pulse");
  AST_NO_BOTH: assert property (!(!port_rw_n && !port_oe_n))
    else $error("Write and read strobes together");
  AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer late");
  AST_BUSY_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write taken while response pending");
  AST_R_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Read taken while data pending");
endmodule
bind dps_sem_host dps_sem_host_asserts #(.SETUP_CYC(SETUP_CYC)) u_chk (.*);
`default_nettype wire

// *** tb/testbench.sv ***
`include "dps_defs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 1'b0, aresetn = 1'b0, bsy = 1'b0, o_wr = 1'b0, o_val = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [2:0]  o_idx = 3'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        port_ce_n, port_semaphore_select_n, port_rw_n, port_oe_n, port_data_oe;
  logic        port_busy_n, ms_sel;
  logic [16:0] port_addr;
  logic [8:0]  port_data_o, port_data_i;
  logic [7:0]  o_flag;
  logic [33:0] eq[$], mq[$];
  logic [1:0]  bq[$];
  int          err_count = 0, cmp_count = 0;
  dps_sem_host uut (.*);
  dps_dev_model u_dev (.*);
  always #10 aclk = ~aclk;
  // ********************************
  // Bus tasks and result checking
  // ********************************
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Negedge sample shows what the next edge takes
  always @(negedge aclk)
  begin
    logic [33:0] m;
    if (s_axi_rvalid && s_axi_rready) m = mq.pop_front();
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata} & m, eq.pop_front() & m);
    if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw = 1'b1;
    logic w = 1'b1;
    bq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w)
    begin
      @(negedge aclk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      @(posedge aclk);
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    while (!s_axi_bvalid) @(negedge aclk);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m,
                    output logic [31:0] d);
    eq.push_back(e);
    mq.push_back(m);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, {2'h0, e}, {34{1'b1}}, d);
  endtask
  task automatic run(input logic [2:0] op, input logic [31:0] st);
    logic [31:0] d;
    wr(`DPS_REG_CTRL, {29'h0, op}, `DPS_RESP_OKAY);
    d = 32'h0;
    while (d[`DPS_ST_DONE] !== 1'b1) rd(`DPS_REG_STATUS, 34'h0, 34'h0, d);
    rdc(`DPS_REG_STATUS, st);
  endtask
  task automatic oth(input logic [2:0] i, input logic v);
    @(posedge aclk);
    o_idx <= i;
    o_val <= v;
    o_wr <= 1'b1;
    @(posedge aclk);
    o_wr <= 1'b0;
  endtask
  task automatic conclude();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ********************************
  // Scenarios
  // ********************************
  initial
  begin
    logic [31:0] d;
    logic [2:0]  a;
    logic [16:0] ma;
    logic [8:0]  md;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    d = $urandom(32'h59268baa);
    rdc(`DPS_REG_CFG, `DPS_CFG_RESET);
    rdc(`DPS_REG_CTRL, 32'h0);
    chk({33'h0, ms_sel}, 34'h1);
    rd(8'h18, {`DPS_RESP_SLVERR, 32'h0}, {2'h3, 32'h0}, d);
    wr(8'h18, 32'h0, `DPS_RESP_SLVERR);
    for (int i = 0; i < 8; i++) oth(3'(i), 1'b1);
    run(`DPS_OP_INIT, 32'h2);
    a = 3'($urandom());
    wr(`DPS_REG_ADDR, {18'h0, 11'($urandom()), a}, `DPS_RESP_OKAY);
    run(`DPS_OP_ACQUIRE, 32'h6);
    chk({33'h0, o_flag[a]}, 34'h1);
    oth(a, 1'b0);
    run(`DPS_OP_RELEASE, 32'h2);
    chk({33'h0, o_flag[a]}, 34'h0);
    wr(`DPS_REG_CFG, 32'h0000_0201, `DPS_RESP_OKAY);
    run(`DPS_OP_ACQUIRE, 32'h12);
    oth(a, 1'b1);
    oth(a, 1'b0);
    chk({33'h0, o_flag[a]}, 34'h0);
    ma = 17'($urandom());
    md = 9'($urandom());
    wr(`DPS_REG_ADDR, {15'h0, ma}, `DPS_RESP_OKAY);
    wr(`DPS_REG_WDATA, {23'h0, md}, `DPS_RESP_OKAY);
    bsy <= 1'b1;
    fork
      run(`DPS_OP_MEM_WR, 32'ha);
      begin
        repeat (40) @(posedge aclk);
        bsy <= 1'b0;
      end
    join
    run(`DPS_OP_MEM_RD, 32'h2);
    rdc(`DPS_REG_RDATA, {23'h0, md});
    oth(a, 1'b1);
    wr(`DPS_REG_ADDR, {14'h0, a}, `DPS_RESP_OKAY);
    run(`DPS_OP_ACQUIRE, 32'h6);
    run(`DPS_OP_RELEASE, 32'h2);
    chk({33'h0, o_flag[a]}, 34'h1);
    wr(`DPS_REG_CFG, 32'h0, `DPS_RESP_OKAY);
    chk({33'h0, ms_sel}, 34'h0);
    conclude();
  end
  initial
  begin
    #1_000_000;
    err_count++;
    conclude();
  end
endmodule
`default_nettype wire
